// ### rtl/chg_pkg.sv
// constants for the charger setting register bank
package chg_pkg;
    // ===========================================
    // register offsets and widths
    localparam logic [7:0] OFS_CHARGE   = 8'h0F;
    localparam logic [7:0] OFS_MISC     = 8'h10;
    localparam logic [7:0] OFS_DERATE   = 8'h11;
    localparam logic [7:0] OFS_THERM    = 8'h12;
    localparam int         VAL_W        = 12;
    typedef logic [VAL_W-1:0] milli_t;
    // ===========================================
    // field positions
    localparam int POS_LOWBAT  = 5;
    localparam int POS_RECON   = 2;
    localparam int POS_VDERATE = 2;
    localparam int POS_COLD    = 5;
    localparam int POS_HOT     = 2;
    localparam int POS_COOL    = 1;
    // ===========================================
    // values after reset
    localparam logic [3:0] RST_FAST_CHARGE = 4'h6;
    localparam logic [1:0] RST_LOW_BATTERY = 2'h1;
    localparam logic [2:0] RST_RECONNECT   = 3'h3;
    localparam logic [1:0] RST_INPUT_CAP   = 2'h0;
    localparam logic [1:0] RST_V_DERATE    = 2'h2;
    localparam logic [1:0] RST_I_DERATE    = 2'h0;
    localparam logic [2:0] RST_COLD        = 3'h5;
    localparam logic [2:0] RST_HOT         = 3'h3;
    localparam logic       RST_COOL_SEL    = 1'b0;
    localparam logic       RST_MILD_SEL    = 1'b0;
    // ===========================================
    // code ranges and decode figures, in mA and mV
    localparam logic [3:0] FAST_CHARGE_MAX = 4'hE;
    localparam logic [2:0] RECONNECT_MAX   = 3'h5;
    localparam int FAST_BASE_MA   = 400;
    localparam int STEP_100       = 100;
    localparam int RECON_BASE_MV  = 3100;
    localparam int I_DERATE_BASE  = 400;
    localparam int CAP_MA0        = 100;
    localparam int CAP_MA1        = 500;
    localparam int CAP_MA2        = 900;
    localparam int CAP_MA3        = 1500;
    localparam int COLD_REF_MV    = 1725;
    localparam int COLD_REF_CODE  = 5;
    localparam int HOT_REF_MV     = 525;
    localparam int HOT_REF_CODE   = 3;
    localparam int THERM_STEP_MV  = 146;
    localparam int OFFSET_WIDE_MV = 219;
    // ===========================================
    // serial bus engine states, gray along the usual path
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_AACK = 4'h3,
        ST_PTR  = 4'h2,
        ST_PACK = 4'h6,
        ST_WR   = 4'h7,
        ST_WACK = 4'h5,
        ST_RD   = 4'h4,
        ST_RACK = 4'hC
    } bus_state_t;
endpackage

// ### rtl/charger_setting_registers.sv
// charger setting registers behind a two-wire serial slave
// Operation
// - fast charge 400 mA plus 100 mA steps, default 6
// - weak battery current off/100/200/300 mA, default 1
// - reconnect 3.1 V plus 0.1 V steps, default 3
// - input cap 100/500/900/1500 mA, default 0
// - voltage derate 0..300 mV, default 2
// - current derate 400..700 mA, default 0
// - cold threshold top bits, default 5, 146 mV step
// - hot threshold bits 4:2, default 3, 146 mV step
// - bit1 picks cool offset 146 or 219 mV
// - bit0 picks warm offset 146 or 219 mV
`timescale 1ns/1ns
module charger_setting_registers #(
    parameter logic [6:0] DEV_ADDR = 7'h36
) (
    input  wire logic           sys_clk,
    input  wire logic           rst_n,
    input  wire logic           scl_in,
    input  wire logic           sda_in,
    output logic                sda_out,
    output logic                sda_oe,
    input  wire logic           charger_off,
    input  wire logic           reg_reset_req,
    input  wire logic           host_boost_mode,
    output logic [3:0]          fast_charge_current,
    output logic [1:0]          low_battery_charge_current,
    output logic [2:0]          reconnect_threshold,
    output logic [1:0]          input_current_cap,
    output logic [1:0]          temp_voltage_derate,
    output logic [1:0]          temp_current_derate,
    output logic [2:0]          cold_threshold,
    output logic [2:0]          hot_threshold,
    output logic                cool_offset_select,
    output logic                mild_heat_offset_select,
    output chg_pkg::milli_t     fast_charge_ma,
    output chg_pkg::milli_t     low_battery_ma,
    output chg_pkg::milli_t     reconnect_mv,
    output chg_pkg::milli_t     input_cap_ma,
    output chg_pkg::milli_t     voltage_derate_mv,
    output chg_pkg::milli_t     current_derate_ma,
    output chg_pkg::milli_t     cold_mv,
    output chg_pkg::milli_t     hot_mv,
    output chg_pkg::milli_t     cool_offset_mv,
    output chg_pkg::milli_t     mild_heat_offset_mv
);
    import chg_pkg::*;
    default clocking cb_sys @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    // ===========================================
    // setting fields
    logic [3:0] fast_q;
    logic [2:0] recon_q, cold_q, hot_q;
    logic [1:0] lowbat_q, cap_q, vder_q, ider_q;
    logic       cool_q, mild_q;
    milli_t     fast_ma_q, lowbat_ma_q, recon_mv_q, cap_ma_q, vder_mv_q;
    milli_t     ider_ma_q, cold_mv_q, hot_mv_q, cool_mv_q, mild_mv_q;
    // ===========================================
    // bus engine state
    bus_state_t state_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] shift_q, tx_q, ptr_q;
    logic       scl_q, sda_q, rw_q, nack_q, oe_q, sda_out_q;
    function automatic logic [3:0] clamp4(input logic [3:0] v, input logic [3:0] mx);
        clamp4 = (v > mx) ? mx : v;
    endfunction
    function automatic milli_t dec_fast(input logic [3:0] c);
        dec_fast = VAL_W'(FAST_BASE_MA + STEP_100 * int'(c));
    endfunction
    function automatic milli_t dec_recon(input logic [2:0] c);
        dec_recon = VAL_W'(RECON_BASE_MV + STEP_100 * int'(c));
    endfunction
    function automatic milli_t dec_cap(input logic [1:0] c);
        dec_cap = (c == 2'h0) ? VAL_W'(CAP_MA0) : (c == 2'h1) ? VAL_W'(CAP_MA1) :
                  (c == 2'h2) ? VAL_W'(CAP_MA2) : VAL_W'(CAP_MA3);
    endfunction
    function automatic milli_t dec_therm(input logic [2:0] c, input int ref_mv, input int ref_code);
        dec_therm = VAL_W'(ref_mv + THERM_STEP_MV * (int'(c) - ref_code));
    endfunction
    function automatic milli_t dec_offset(input logic wide);
        dec_offset = wide ? VAL_W'(OFFSET_WIDE_MV) : VAL_W'(THERM_STEP_MV);
    endfunction
    // ===========================================
    // bus decode
    wire       scl_rise   = scl_in & ~scl_q;
    wire       scl_fall   = ~scl_in & scl_q;
    wire       start_cond = scl_in & scl_q & sda_q & ~sda_in;
    wire       stop_cond  = scl_in & scl_q & ~sda_q & sda_in;
    wire       byte_done  = (bit_cnt_q == 4'h8);
    wire       addr_hit   = (shift_q[7:1] == DEV_ADDR);
    wire       in_rx      = (state_q == ST_ADDR) || (state_q == ST_PTR) || (state_q == ST_WR);
    wire       wr_stb     = scl_fall && (state_q == ST_WR) && byte_done;
    // any of the documented reset events; held as a level, so the fields stay at default
    wire       reload     = charger_off | reg_reset_req | host_boost_mode;
    // reserved bits and unmapped offsets read back as zero
    wire [7:0] rd_data    = (ptr_q == OFS_CHARGE) ? {4'h0, fast_q} :
                            (ptr_q == OFS_MISC)   ? {1'b0, lowbat_q, recon_q, cap_q} :
                            (ptr_q == OFS_DERATE) ? {4'h0, vder_q, ider_q} :
                            (ptr_q == OFS_THERM)  ? {cold_q, hot_q, cool_q, mild_q} : 8'h00;
    wire [3:0] recon_clamp = clamp4({1'b0, shift_q[POS_RECON +: 3]}, {1'b0, RECONNECT_MAX});
    // ===========================================
    // serial slave: inputs sampled on sys_clk, so bus rates near a quarter of it are out of reach
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q   <= ST_IDLE;
            scl_q     <= 1'b1;
            sda_q     <= 1'b1;
            bit_cnt_q <= 4'h0;
            shift_q   <= 8'h00;
            tx_q      <= 8'h00;
            ptr_q     <= 8'h00;
            rw_q      <= 1'b0;
            nack_q    <= 1'b0;
            oe_q      <= 1'b0;
            sda_out_q <= 1'b0;
        end else begin
            scl_q     <= scl_in;
            sda_q     <= sda_in;
            sda_out_q <= 1'b0;
            if (start_cond) begin
                state_q   <= ST_ADDR;
                bit_cnt_q <= 4'h0;
                oe_q      <= 1'b0;
            end else if (stop_cond) begin
                state_q <= ST_IDLE;
                oe_q    <= 1'b0;
            end else if (scl_rise) begin
                if (in_rx) begin
                    shift_q   <= {shift_q[6:0], sda_in};
                    bit_cnt_q <= bit_cnt_q + 4'h1;
                end else if (state_q == ST_RD) begin
                    bit_cnt_q <= bit_cnt_q + 4'h1;
                end else if (state_q == ST_RACK) begin
                    nack_q <= sda_in;
                end
            end else if (scl_fall) begin
                case (state_q)
                    ST_ADDR: begin
                        if (byte_done) begin
                            state_q   <= addr_hit ? ST_AACK : ST_IDLE;
                            oe_q      <= addr_hit;
                            rw_q      <= shift_q[0];
                            bit_cnt_q <= 4'h0;
                        end
                    end
                    ST_AACK, ST_RACK: begin
                        if (state_q == ST_RACK && nack_q) begin
                            state_q <= ST_IDLE;
                            oe_q    <= 1'b0;
                        end else if (rw_q) begin
                            state_q   <= ST_RD;
                            tx_q      <= rd_data;
                            oe_q      <= ~rd_data[7];
                            ptr_q     <= ptr_q + 8'h01;
                            bit_cnt_q <= 4'h0;
                        end else begin
                            state_q <= ST_PTR;
                            oe_q    <= 1'b0;
                        end
                    end
                    ST_PTR: begin
                        if (byte_done) begin
                            state_q   <= ST_PACK;
                            oe_q      <= 1'b1;
                            ptr_q     <= shift_q;
                            bit_cnt_q <= 4'h0;
                        end
                    end
                    ST_PACK, ST_WACK: begin
                        state_q <= ST_WR;
                        oe_q    <= 1'b0;
                    end
                    ST_WR: begin
                        if (byte_done) begin
                            state_q   <= ST_WACK;
                            oe_q      <= 1'b1;
                            ptr_q     <= ptr_q + 8'h01;
                            bit_cnt_q <= 4'h0;
                        end
                    end
                    ST_RD: begin
                        if (byte_done) begin
                            state_q   <= ST_RACK;
                            oe_q      <= 1'b0;
                            bit_cnt_q <= 4'h0;
                        end else begin
                            tx_q <= {tx_q[6:0], 1'b0};
                            oe_q <= ~tx_q[6];
                        end
                    end
                    default: begin
                        state_q <= ST_IDLE;
                        oe_q    <= 1'b0;
                    end
                endcase
            end
        end
    end
    // ===========================================
    // setting fields; a reset event beats a write in the same cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            fast_q   <= RST_FAST_CHARGE;
            lowbat_q <= RST_LOW_BATTERY;
            recon_q  <= RST_RECONNECT;
            cap_q    <= RST_INPUT_CAP;
            vder_q   <= RST_V_DERATE;
            ider_q   <= RST_I_DERATE;
            cold_q   <= RST_COLD;
            hot_q    <= RST_HOT;
            cool_q   <= RST_COOL_SEL;
            mild_q   <= RST_MILD_SEL;
        end else if (reload) begin
            {fast_q, lowbat_q, recon_q, cap_q, vder_q, ider_q, cold_q, hot_q, cool_q, mild_q} <=
                {RST_FAST_CHARGE, RST_LOW_BATTERY, RST_RECONNECT, RST_INPUT_CAP, RST_V_DERATE,
                 RST_I_DERATE, RST_COLD, RST_HOT, RST_COOL_SEL, RST_MILD_SEL};
        end else if (wr_stb) begin
            case (ptr_q)
                OFS_CHARGE: fast_q <= clamp4(shift_q[3:0], FAST_CHARGE_MAX);
                OFS_MISC: begin
                    lowbat_q <= shift_q[POS_LOWBAT +: 2];
                    recon_q  <= recon_clamp[2:0];
                    cap_q    <= shift_q[1:0];
                end
                OFS_DERATE: begin
                    vder_q <= shift_q[POS_VDERATE +: 2];
                    ider_q <= shift_q[1:0];
                end
                OFS_THERM: begin
                    cold_q <= shift_q[POS_COLD +: 3];
                    hot_q  <= shift_q[POS_HOT +: 3];
                    cool_q <= shift_q[POS_COOL];
                    mild_q <= shift_q[0];
                end
                default: ;
            endcase
        end
    end
    // ===========================================
    // decoded physical values, one cycle behind the fields
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            fast_ma_q   <= dec_fast(RST_FAST_CHARGE);
            lowbat_ma_q <= VAL_W'(STEP_100 * int'(RST_LOW_BATTERY));
            recon_mv_q  <= dec_recon(RST_RECONNECT);
            cap_ma_q    <= dec_cap(RST_INPUT_CAP);
            vder_mv_q   <= VAL_W'(STEP_100 * int'(RST_V_DERATE));
            ider_ma_q   <= VAL_W'(I_DERATE_BASE + STEP_100 * int'(RST_I_DERATE));
            cold_mv_q   <= dec_therm(RST_COLD, COLD_REF_MV, COLD_REF_CODE);
            hot_mv_q    <= dec_therm(RST_HOT, HOT_REF_MV, HOT_REF_CODE);
            cool_mv_q   <= dec_offset(RST_COOL_SEL);
            mild_mv_q   <= dec_offset(RST_MILD_SEL);
        end else begin
            fast_ma_q   <= dec_fast(fast_q);
            lowbat_ma_q <= VAL_W'(STEP_100 * int'(lowbat_q));
            recon_mv_q  <= dec_recon(recon_q);
            cap_ma_q    <= dec_cap(cap_q);
            vder_mv_q   <= VAL_W'(STEP_100 * int'(vder_q));
            ider_ma_q   <= VAL_W'(I_DERATE_BASE + STEP_100 * int'(ider_q));
            cold_mv_q   <= dec_therm(cold_q, COLD_REF_MV, COLD_REF_CODE);
            hot_mv_q    <= dec_therm(hot_q, HOT_REF_MV, HOT_REF_CODE);
            cool_mv_q   <= dec_offset(cool_q);
            mild_mv_q   <= dec_offset(mild_q);
        end
    end
    assign sda_out                    = sda_out_q;
    assign sda_oe                     = oe_q;
    assign fast_charge_current        = fast_q;
    assign low_battery_charge_current = lowbat_q;
    assign reconnect_threshold        = recon_q;
    assign input_current_cap          = cap_q;
    assign temp_voltage_derate        = vder_q;
    assign temp_current_derate        = ider_q;
    assign cold_threshold             = cold_q;
    assign hot_threshold              = hot_q;
    assign cool_offset_select         = cool_q;
    assign mild_heat_offset_select    = mild_q;
    assign fast_charge_ma             = fast_ma_q;
    assign low_battery_ma             = lowbat_ma_q;
    assign reconnect_mv               = recon_mv_q;
    assign input_cap_ma               = cap_ma_q;
    assign voltage_derate_mv          = vder_mv_q;
    assign current_derate_ma          = ider_ma_q;
    assign cold_mv                    = cold_mv_q;
    assign hot_mv                     = hot_mv_q;
    assign cool_offset_mv             = cool_mv_q;
    assign mild_heat_offset_mv        = mild_mv_q;
    // ===========================================
    // checks
    sequence s_fast_write;
        wr_stb && ptr_q == OFS_CHARGE && !reload;
    endsequence
    property p_fast;
        s_fast_write |=> ##1 fast_charge_ma == 12'd400 + 12'd100 * 12'($past(fast_q)) && fast_q <= 4'hE;
    endproperty
    a_fast: assert property (p_fast) else $error("fast charge decode wrong");
    property p_lowbat;
        ##1 low_battery_ma == 12'd100 * 12'($past(lowbat_q));
    endproperty
    a_lowbat: assert property (p_lowbat) else $error("weak battery current wrong");
    property p_recon;
        recon_q <= 3'h5 ##1 reconnect_mv == 12'd3100 + 12'd100 * 12'($past(recon_q));
    endproperty
    a_recon: assert property (p_recon) else $error("reconnect threshold wrong");
    property p_cap;
        cap_q == 2'h3 |=> input_cap_ma == 12'd1500;
    endproperty
    a_cap: assert property (p_cap) else $error("input cap decode wrong");
    property p_vder;
        $changed(vder_q) |=> voltage_derate_mv == 12'd100 * 12'($past(vder_q));
    endproperty
    a_vder: assert property (p_vder) else $error("voltage derate wrong");
    property p_ider;
        ##1 current_derate_ma == 12'd400 + 12'd100 * 12'($past(ider_q));
    endproperty
    a_ider: assert property (p_ider) else $error("current derate wrong");
    property p_reload;
        reload |=> fast_q == 4'h6 && lowbat_q == 2'h1 && recon_q == 3'h3 && vder_q == 2'h2 ##1 cold_mv == 12'd1725;
    endproperty
    a_reload: assert property (p_reload) else $error("defaults not reloaded");
    property p_hot;
        hot_q == 3'h4 |=> hot_mv == 12'd671;
    endproperty
    a_hot: assert property (p_hot) else $error("hot threshold wrong");
    property p_offsets;
        ##1 cool_offset_mv == ($past(cool_q) ? 12'd219 : 12'd146) &&
            mild_heat_offset_mv == ($past(mild_q) ? 12'd219 : 12'd146);
    endproperty
    a_offsets: assert property (p_offsets) else $error("offset select wrong");
    property p_reserved;
        scl_fall && (state_q == ST_AACK) && rw_q && (ptr_q == OFS_CHARGE) |=> tx_q[7:4] == 4'h0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits not zero");
endmodule

// ### verif/charger_setting_registers_tb_top.sv
// self-checking bench for the charger setting register bank
`timescale 1ns/1ns
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module charger_setting_registers_tb_top;
    import chg_pkg::*;
    // ===========================================
    // clock, reset, wires
    localparam logic [6:0] ADDR = 7'h36;
    logic       sys_clk, rst_n, scl, m_sda, sda_out, sda_oe;
    logic [2:0] rl;
    logic [3:0] fc;
    logic [1:0] lb, ic, vd, idr;
    logic [2:0] rc, cth, hth;
    logic       cs, ms;
    milli_t     fc_ma, lb_ma, rc_mv, ic_ma, vd_mv, id_ma, c_mv, h_mv, cs_mv, ms_mv;
    int         n_errors = 0;
    int         n_tests = 0;
    // open drain: either party may pull the data line low
    wire        sda = m_sda & (sda_oe ? sda_out : 1'b1);
    charger_setting_registers #(.DEV_ADDR(ADDR)) dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .charger_off(rl[0]), .reg_reset_req(rl[1]), .host_boost_mode(rl[2]),
        .fast_charge_current(fc), .low_battery_charge_current(lb), .reconnect_threshold(rc),
        .input_current_cap(ic), .temp_voltage_derate(vd), .temp_current_derate(idr),
        .cold_threshold(cth), .hot_threshold(hth), .cool_offset_select(cs), .mild_heat_offset_select(ms),
        .fast_charge_ma(fc_ma), .low_battery_ma(lb_ma), .reconnect_mv(rc_mv), .input_cap_ma(ic_ma),
        .voltage_derate_mv(vd_mv), .current_derate_ma(id_ma), .cold_mv(c_mv), .hot_mv(h_mv),
        .cool_offset_mv(cs_mv), .mild_heat_offset_mv(ms_mv));
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // ===========================================
    // serial bus master, eight clocks per bit, SCL high for four of them
    task automatic w(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic bit_io(input logic b, output logic r);
        m_sda <= b; w(2); scl <= 1'b1; w(4);
        r = sda;
        scl <= 1'b0; w(2);
    endtask
    task automatic start();
        m_sda <= 1'b1; w(2); scl <= 1'b1; w(4); m_sda <= 1'b0; w(4); scl <= 1'b0; w(2);
    endtask
    task automatic stop();
        m_sda <= 1'b0; w(2); scl <= 1'b1; w(4); m_sda <= 1'b1; w(4);
    endtask
    task automatic wbyte(input logic [7:0] d, input logic exp_ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        `CHK(~r, exp_ack);
    endtask
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(last, r);
    endtask
    // burst write, pointer advances per byte, first byte from byte n-1 of d, last from the bottom byte
    task automatic wr(input logic [7:0] ofs, input int n, input logic [31:0] d);
        start(); wbyte({ADDR, 1'b0}, 1'b1); wbyte(ofs, 1'b1);
        for (int i = n - 1; i >= 0; i--) wbyte(d[8*i +: 8], 1'b1);
        stop();
    endtask
    task automatic rd(input logic [7:0] ofs, output logic [7:0] d);
        start(); wbyte({ADDR, 1'b0}, 1'b1); wbyte(ofs, 1'b1);
        start(); wbyte({ADDR, 1'b1}, 1'b1); rbyte(1'b1, d); stop();
    endtask
    task automatic rd_chk(input logic [7:0] ofs, input logic [7:0] e);
        logic [7:0] d;
        rd(ofs, d);
        `CHK(d, e);
    endtask
    // ===========================================
    // scenarios
    task automatic t_defaults();
        rd_chk(OFS_CHARGE, 8'h06);
        rd_chk(OFS_MISC, 8'h2C);
        rd_chk(OFS_DERATE, 8'h08);
        rd_chk(OFS_THERM, 8'hAC);
        `CHK({fc, lb, rc, ic, vd, idr}, {4'h6, 2'h1, 3'h3, 2'h0, 2'h2, 2'h0});
        `CHK({cth, hth, cs, ms}, {3'h5, 3'h3, 1'b0, 1'b0});
        `CHK({fc_ma, lb_ma, rc_mv, ic_ma, vd_mv}, {12'd1000, 12'd100, 12'd3400, 12'd100, 12'd200});
        `CHK({id_ma, c_mv, h_mv, cs_mv, ms_mv}, {12'd400, 12'd1725, 12'd525, 12'd146, 12'd146});
    endtask
    // all ones into every bank register in one burst: clamps and reserved bits
    task automatic t_all_ones();
        wr(OFS_CHARGE, 4, 32'hFFFF_FFFF);
        rd_chk(OFS_CHARGE, 8'h0E);
        rd_chk(OFS_MISC, 8'h77);
        rd_chk(OFS_DERATE, 8'h0F);
        rd_chk(OFS_THERM, 8'hFF);
        `CHK({fc_ma, lb_ma, rc_mv, ic_ma, vd_mv}, {12'd1800, 12'd300, 12'd3600, 12'd1500, 12'd300});
        `CHK({id_ma, c_mv, h_mv, cs_mv, ms_mv}, {12'd700, 12'd2017, 12'd1109, 12'd219, 12'd219});
    endtask
    task automatic t_codes();
        int      cap_tab[4];
        logic [1:0] c;
        cap_tab = '{CAP_MA0, CAP_MA1, CAP_MA2, CAP_MA3};
        for (int k = 0; k < 4; k++) begin
            c = 2'(k);
            wr(OFS_MISC, 3, {8'h00, 1'b0, c, 1'b0, c, c, 4'h0, c, c, 3'(k), 3'(k + 1), c});
            rd_chk(OFS_MISC, {1'b0, c, 1'b0, c, c});
            `CHK(lb_ma, milli_t'(STEP_100 * k));
            `CHK(rc_mv, milli_t'(RECON_BASE_MV + STEP_100 * k));
            `CHK(ic_ma, milli_t'(cap_tab[k]));
            `CHK(vd_mv, milli_t'(STEP_100 * k));
            `CHK(id_ma, milli_t'(I_DERATE_BASE + STEP_100 * k));
            `CHK(c_mv, milli_t'(COLD_REF_MV + THERM_STEP_MV * (k - COLD_REF_CODE)));
            `CHK(h_mv, milli_t'(HOT_REF_MV + THERM_STEP_MV * (k + 1 - HOT_REF_CODE)));
            `CHK(cs_mv, milli_t'(c[1] ? OFFSET_WIDE_MV : THERM_STEP_MV));
            `CHK(ms_mv, milli_t'(c[0] ? OFFSET_WIDE_MV : THERM_STEP_MV));
        end
    endtask
    // each reload source on its own brings the defaults back
    task automatic t_reload();
        for (int k = 0; k < 3; k++) begin
            wr(OFS_CHARGE, 4, 32'h0100_0000);
            rl <= 3'(1 << k); w(4);
            `CHK({fc, lb, rc, vd, cth, hth}, {4'h6, 2'h1, 3'h3, 2'h2, 3'h5, 3'h3});
            rl <= 3'h0; w(2);
            rd_chk(OFS_THERM, 8'hAC);
        end
    endtask
    task automatic t_unmapped();
        wr(8'h13, 1, 32'h0000_005A);
        rd_chk(8'h13, 8'h00);
        start(); wbyte({ADDR ^ 7'h01, 1'b0}, 1'b0); stop();
        rd_chk(OFS_CHARGE, 8'h06);
    endtask
    // ===========================================
    // run control
    task automatic tally_and_finish();
        $display("comparisons=%0d mismatches=%0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        rst_n = 1'b0; scl = 1'b1; m_sda = 1'b1; rl = 3'h0;
        w(2);
        rst_n <= 1'b1;
        w(2);
        t_defaults();
        t_all_ones();
        t_codes();
        t_reload();
        t_unmapped();
        tally_and_finish();
    end
    // all scenarios need roughly 9200 clocks
    initial begin
        repeat (60000) @(posedge sys_clk);
        n_errors++;
        tally_and_finish();
    end
endmodule
